/* design/pgm_gpio_ctrl.sv */
// Functional notes
// (R1) Pin three output: level one releases, zero pulls
// (R2) Pin three input: edge-selected conversion trigger
// (R3) Pin two output: level one releases, zero pulls
// (R4) Pin one output: level one releases, zero pulls
// (R5) Pin two edge drives interrupt, polarity selects
// (R6) Pin one edge drives interrupt, polarity selects
// (R7) Pin two level requests converter two
// (R8) Pin one level requests converter one
// (R9) Pin one level requests standby, both converters
// (R10) Host: interrupt use clears converter, standby controls
// (R11) Host: converter-one use clears interrupt, standby
// (R12) Host: converter-two use clears interrupt enable
// (R13) Two read/write byte registers at 1B, 1C
// (R14) Power-up: pins input, no mode selected
// (R15) Interrupt releases after two edges plus read
// (R16) Undervoltage or output mode also releases interrupt
// (R17) Converter acts only when register and pin agree
// (R18) Output mode disables all input-side functions
`timescale 1ns/1ps

module pgm_gpio_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic pin_one_in,
    output logic pin_one_out,
    output logic pin_one_oe,
    input wire logic pin_two_in,
    output logic pin_two_out,
    output logic pin_two_oe,
    input wire logic pin_three_in,
    output logic pin_three_out,
    output logic pin_three_oe,
    input wire logic pin_three_conv_trigger_en,
    input wire logic pin_three_trigger_edge,
    input wire logic buck_one_reg_en,
    input wire logic buck_two_reg_en,
    input wire logic buck_standby_reg_cmd,
    input wire logic uvlo,
    output logic irq_n,
    output logic buck_one_on,
    output logic buck_two_on,
    output logic buck_standby,
    output logic conv_trigger,
    output logic regulator_zero_on,
    output logic charge_voltage_sel
);
    import pgm_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pgm_i2c_e st;
        logic [2:0] cnt;
        logic got;
        logic rw;
        logic nack;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic sda_oe;
        logic sda_out;
        logic scl_q;
        logic sda_q;
        logic [7:0] cfg12;
        logic [7:0] cfg3;
        logic [2:0] pin_q;
        logic [2:0] pin_oe;
        logic [2:0] pin_out;
        logic [1:0] tog;
        logic [1:0] irq_lat;
        logic irq_n;
        logic buck_one_on;
        logic buck_two_on;
        logic buck_standby;
        logic conv_trigger;
        logic regulator_zero_on;
        logic charge_voltage_sel;
    } pgm_state_s;

    pgm_state_s s;
    pgm_state_s next_s;

    function automatic logic [7:0] reg_read(
        input logic [7:0] a,
        input logic [7:0] c12,
        input logic [7:0] c3
    );
        case (a)
            ADDR_PINS_ONE_TWO_CFG: reg_read = c12;
            ADDR_PIN_THREE_MISC_CFG: reg_read = c3;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic rd_evt;
        logic [2:0] pin_in;
        logic [2:0] rise;
        logic [2:0] fall;
        logic [1:0] dir;
        logic [1:0] pol;
        logic [1:0] irq_en;
        logic [1:0] edge_sel;
        logic [1:0] pin_req;
        logic in_three;
        logic [7:0] rd_byte;
        int i;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        rd_evt = 1'b0;
        pin_in = '0;
        rise = '0;
        fall = '0;
        dir = '0;
        pol = '0;
        irq_en = '0;
        edge_sel = '0;
        pin_req = '0;
        in_three = 1'b0;
        rd_byte = reg_read(s.ptr, s.cfg12, s.cfg3);
        i = 0;
        next_s = s;

        // ---------------- Serial register port ----------------
        scl_rise = scl & ~s.scl_q;
        scl_fall = ~scl & s.scl_q;
        start_c = scl & s.scl_q & s.sda_q & ~sda_in;
        stop_c = scl & s.scl_q & ~s.sda_q & sda_in;
        next_s.scl_q = scl;
        next_s.sda_q = sda_in;

        if (start_c) begin
            next_s.st = ST_ADDR;
            next_s.cnt = 3'h0;
            next_s.got = 1'b0;
            next_s.sda_oe = 1'b0;
        end else if (stop_c) begin
            next_s.st = ST_IDLE;
            next_s.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (s.st)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    next_s.sh = {s.sh[6:0], sda_in};
                    next_s.cnt = s.cnt + 3'h1;
                    next_s.got = (s.cnt == 3'h7);
                end
                ST_RDATA: begin
                    next_s.cnt = s.cnt + 3'h1;
                    next_s.got = (s.cnt == 3'h7);
                end
                ST_RACK: next_s.nack = sda_in;
                default: next_s.got = 1'b0;
            endcase
        end else if (scl_fall) begin
            case (s.st)
                ST_ADDR: begin
                    if (s.got) begin
                        next_s.got = 1'b0;
                        if (s.sh[7:1] == I2C_DEV_ADDR) begin
                            next_s.rw = s.sh[0];
                            next_s.sda_oe = 1'b1;
                            next_s.st = ST_AACK;
                        end else begin
                            next_s.st = ST_IDLE;
                        end
                    end
                end
                ST_PTR: begin
                    if (s.got) begin
                        next_s.got = 1'b0;
                        next_s.ptr = s.sh;
                        next_s.sda_oe = 1'b1;
                        next_s.st = ST_PACK;
                    end
                end
                ST_WDATA: begin
                    if (s.got) begin
                        next_s.got = 1'b0;
                        // Every bit of both registers is writable (R13)
                        if (s.ptr == ADDR_PINS_ONE_TWO_CFG) begin
                            next_s.cfg12 = s.sh;
                        end else if (s.ptr == ADDR_PIN_THREE_MISC_CFG) begin
                            next_s.cfg3 = s.sh;
                        end
                        next_s.ptr = s.ptr + 8'h01;
                        next_s.sda_oe = 1'b1;
                        next_s.st = ST_WACK;
                    end
                end
                ST_AACK: begin
                    next_s.cnt = 3'h0;
                    if (s.rw) begin
                        next_s.sh = rd_byte;
                        next_s.sda_oe = ~rd_byte[7];
                        next_s.st = ST_RDATA;
                        rd_evt = 1'b1;
                    end else begin
                        next_s.sda_oe = 1'b0;
                        next_s.st = ST_PTR;
                    end
                end
                ST_PACK, ST_WACK: begin
                    next_s.sda_oe = 1'b0;
                    next_s.cnt = 3'h0;
                    next_s.st = ST_WDATA;
                end
                ST_RDATA: begin
                    if (s.got) begin
                        next_s.got = 1'b0;
                        next_s.sda_oe = 1'b0;
                        next_s.ptr = s.ptr + 8'h01;
                        next_s.st = ST_RACK;
                    end else begin
                        next_s.sda_oe = ~s.sh[3'h7 - s.cnt];
                    end
                end
                ST_RACK: begin
                    if (s.nack) begin
                        next_s.st = ST_IDLE;
                    end else begin
                        next_s.sh = rd_byte;
                        next_s.sda_oe = ~rd_byte[7];
                        next_s.cnt = 3'h0;
                        next_s.st = ST_RDATA;
                        rd_evt = 1'b1;
                    end
                end
                default: next_s.st = ST_IDLE;
            endcase
        end
        next_s.sda_out = 1'b0;

        // ---------------- Pin drivers ----------------
        // Open drain: only ever pull low, never drive high
        next_s.pin_out = 3'h0;
        next_s.pin_oe[0] = s.cfg12[B12_PIN_ONE_DIR]
            & ~s.cfg12[B12_PIN_ONE_LEVEL]; // R4
        next_s.pin_oe[1] = s.cfg12[B12_PIN_TWO_DIR]
            & ~s.cfg12[B12_PIN_TWO_LEVEL]; // R3
        next_s.pin_oe[2] = s.cfg3[B3_PIN_THREE_DIR]
            & ~s.cfg3[B3_PIN_THREE_LEVEL]; // R1

        // ---------------- Edge detection ----------------
        pin_in = {pin_three_in, pin_two_in, pin_one_in};
        next_s.pin_q = pin_in;
        rise = pin_in & ~s.pin_q;
        fall = ~pin_in & s.pin_q;
        dir = {s.cfg12[B12_PIN_TWO_DIR], s.cfg12[B12_PIN_ONE_DIR]};
        pol = {s.cfg12[B12_PIN_TWO_POLARITY],
               s.cfg12[B12_PIN_ONE_POLARITY]};
        irq_en = {s.cfg3[B3_PIN_TWO_IRQ_EN], s.cfg3[B3_PIN_ONE_IRQ_EN]};

        // ---------------- Interrupt latches ----------------
        for (i = 0; i < 2; i++) begin
            edge_sel[i] = ~dir[i] & irq_en[i]
                & (pol[i] ? fall[i] : rise[i]); // R5 R6 R18
            // A read only releases once the second edge has toggled back
            if (uvlo | dir[i]) begin
                next_s.tog[i] = 1'b0; // R16
                next_s.irq_lat[i] = 1'b0;
            end else if (rd_evt & ~s.tog[i]) begin
                next_s.irq_lat[i] = 1'b0; // R15
            end
            // An edge with tog clear wins over a uvlo or read clear in the same cycle
            if (edge_sel[i]) begin
                next_s.tog[i] = ~s.tog[i]; // R15
                if (~s.tog[i]) begin
                    next_s.irq_lat[i] = 1'b1;
                end
            end
        end
        next_s.irq_n = ~(next_s.irq_lat[0] | next_s.irq_lat[1]);

        // ---------------- Converter control ----------------
        for (i = 0; i < 2; i++) begin
            pin_req[i] = ~(pin_in[i] ^ pol[i]); // R7 R8 R9
        end
        next_s.buck_one_on = buck_one_reg_en
            & ~(~dir[0] & s.cfg12[B12_PIN_ONE_CONV_ONE_CTL]
                & ~pin_req[0]); // R8 R17 R18
        next_s.buck_two_on = buck_two_reg_en
            & ~(~dir[1] & s.cfg3[B3_PIN_TWO_CONV_TWO_CTL]
                & ~pin_req[1]); // R7 R17 R18
        next_s.buck_standby = buck_standby_reg_cmd
            & ~(~dir[0] & s.cfg12[B12_PIN_ONE_STANDBY_CTL]
                & ~pin_req[0]); // R9 R17 R18

        // ---------------- Conversion trigger ----------------
        in_three = ~s.cfg3[B3_PIN_THREE_DIR];
        next_s.conv_trigger = in_three & pin_three_conv_trigger_en
            & (pin_three_trigger_edge ? rise[2] : fall[2]); // R2 R18

        next_s.regulator_zero_on = s.cfg3[B3_REGULATOR_ZERO_ON];
        next_s.charge_voltage_sel = s.cfg3[B3_CHARGE_VOLTAGE_SEL];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.st <= ST_IDLE;
            s.scl_q <= 1'b1;
            s.sda_q <= 1'b1;
            // Pins idle high on pull-ups: no false edge after reset
            s.pin_q <= 3'h7;
            s.cfg12 <= RST_PINS_ONE_TWO_CFG; // R14
            s.cfg3 <= RST_PIN_THREE_MISC_CFG; // R14
            s.irq_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign sda_out = s.sda_out;
    assign sda_oe = s.sda_oe;
    assign pin_one_out = s.pin_out[0];
    assign pin_one_oe = s.pin_oe[0];
    assign pin_two_out = s.pin_out[1];
    assign pin_two_oe = s.pin_oe[1];
    assign pin_three_out = s.pin_out[2];
    assign pin_three_oe = s.pin_oe[2];
    assign irq_n = s.irq_n;
    assign buck_one_on = s.buck_one_on;
    assign buck_two_on = s.buck_two_on;
    assign buck_standby = s.buck_standby;
    assign conv_trigger = s.conv_trigger;
    assign regulator_zero_on = s.regulator_zero_on;
    assign charge_voltage_sel = s.charge_voltage_sel;

endmodule

/* design/pgm_pkg.sv */
package pgm_pkg;

    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    // Seven-bit bus address of the device, value arbitrary
    localparam logic [6:0] I2C_DEV_ADDR = 7'h2a;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_AACK = 4'b0010,
        ST_PTR = 4'b0011,
        ST_PACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RACK = 4'b1000
    } pgm_i2c_e;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PINS_ONE_TWO_CFG = 8'h1b;
    localparam logic [7:0] ADDR_PIN_THREE_MISC_CFG = 8'h1c;
    localparam logic [7:0] RST_PINS_ONE_TWO_CFG = 8'h00;
    localparam logic [7:0] RST_PIN_THREE_MISC_CFG = 8'h00;

    // Fields of pins_one_two_cfg
    localparam int B12_PIN_TWO_DIR = 7;
    localparam int B12_PIN_ONE_DIR = 6;
    localparam int B12_PIN_TWO_LEVEL = 5;
    localparam int B12_PIN_ONE_LEVEL = 4;
    localparam int B12_PIN_TWO_POLARITY = 3;
    localparam int B12_PIN_ONE_POLARITY = 2;
    localparam int B12_PIN_ONE_STANDBY_CTL = 1;
    localparam int B12_PIN_ONE_CONV_ONE_CTL = 0;

    // Fields of pin_three_misc_cfg
    localparam int B3_PIN_THREE_DIR = 7;
    localparam int B3_PIN_THREE_LEVEL = 6;
    localparam int B3_REGULATOR_ZERO_ON = 5;
    localparam int B3_CHARGE_VOLTAGE_SEL = 4;
    localparam int B3_PIN_TWO_IRQ_EN = 2;
    localparam int B3_PIN_ONE_IRQ_EN = 1;
    localparam int B3_PIN_TWO_CONV_TWO_CTL = 0;

endpackage

/* sim/pgm_gpio_ctrl_assertions.sv */
`timescale 1ns/1ps
module pgm_gpio_ctrl_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic pin_one_in,
    input wire logic pin_one_out,
    input wire logic pin_one_oe,
    input wire logic pin_two_in,
    input wire logic pin_two_out,
    input wire logic pin_two_oe,
    input wire logic pin_three_in,
    input wire logic pin_three_out,
    input wire logic pin_three_oe,
    input wire logic pin_three_conv_trigger_en,
    input wire logic buck_one_reg_en,
    input wire logic buck_two_reg_en,
    input wire logic buck_standby_reg_cmd,
    input wire logic uvlo,
    input wire logic irq_n,
    input wire logic buck_one_on,
    input wire logic buck_two_on,
    input wire logic buck_standby,
    input wire logic conv_trigger
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    a_pins_open_drain: assert property (
        !(pin_one_out | pin_two_out | pin_three_out))
        else $error("pin output data not low");
    a_sda_open_drain: assert property (
        !sda_out) else $error("serial data output not low");
    // Register writes land on a serial clock fall only
    a_oe_on_scl_low: assert property (
        $changed({pin_one_oe, pin_two_oe, pin_three_oe}) |-> !$past(scl))
        else $error("pin drive changed outside serial clock low");
    a_sda_on_fall: assert property (
        $changed(sda_oe) |-> !$past(scl) && $past(scl, 2))
        else $error("serial data drive changed off a clock fall");
    a_trig_pulse: assert property (
        conv_trigger |=> !conv_trigger)
        else $error("conversion trigger longer than one cycle");
    a_trig_cause: assert property (
        conv_trigger |-> $past(pin_three_conv_trigger_en)
        && ($past(pin_three_in) != $past(pin_three_in, 2)))
        else $error("conversion trigger without pin edge");
    a_buck_one_gate: assert property (
        buck_one_on |-> $past(buck_one_reg_en))
        else $error("converter one on without register enable");
    a_buck_two_gate: assert property (
        buck_two_on |-> $past(buck_two_reg_en))
        else $error("converter two on without register enable");
    a_standby_gate: assert property (
        buck_standby |-> $past(buck_standby_reg_cmd))
        else $error("standby without register command");
    a_irq_fall_cause: assert property (
        $fell(irq_n) |-> ($past(pin_one_in) != $past(pin_one_in, 2))
        || ($past(pin_two_in) != $past(pin_two_in, 2)))
        else $error("interrupt asserted without pin edge");
    a_uvlo_clears: assert property (
        (uvlo && $stable({pin_one_in, pin_two_in}))[*2] |-> ##[0:1] irq_n)
        else $error("undervoltage did not release interrupt");
endmodule

bind pgm_gpio_ctrl pgm_gpio_ctrl_assertions i_chk (.clk, .rst, .scl,
    .sda_out, .sda_oe, .pin_one_in, .pin_one_out, .pin_one_oe, .pin_two_in,
    .pin_two_out, .pin_two_oe, .pin_three_in, .pin_three_out, .pin_three_oe,
    .pin_three_conv_trigger_en, .buck_one_reg_en, .buck_two_reg_en,
    .buck_standby_reg_cmd, .uvlo, .irq_n, .buck_one_on, .buck_two_on,
    .buck_standby, .conv_trigger);

/* sim/pgm_gpio_ctrl_test.sv */
`timescale 1ns/1ps
module pgm_gpio_ctrl_test;
    import pgm_pkg::*;
    logic clk, rst, scl, sda_m, sda_in, sda_oe, d1, d2, d3, p1, p2, p3;
    logic o1, o2, o3, en, edge_sel, r1, r2, sb, uvlo, irq_n, trig, rz, cv;
    logic b1, b2, bs;
    logic [7:0] n_trig = 8'h00;
    int n_checks, n_mismatch;
    // ------------------------------------------------------------
    // Wires with pull-ups
    // ------------------------------------------------------------
    assign sda_in = sda_m & ~sda_oe;
    assign p1 = d1 & ~o1;
    assign p2 = d2 & ~o2;
    assign p3 = d3 & ~o3;
    initial clk = 1'b0;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (trig === 1'b1) begin
            n_trig <= n_trig + 8'h01;
        end
    end
    pgm_host_model i_host (.clk(clk), .sda(sda_in), .scl(scl),
        .sda_m(sda_m));
    pgm_gpio_ctrl i_dut (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in),
        .sda_out(), .sda_oe(sda_oe), .pin_one_in(p1), .pin_one_out(),
        .pin_one_oe(o1), .pin_two_in(p2), .pin_two_out(), .pin_two_oe(o2),
        .pin_three_in(p3), .pin_three_out(), .pin_three_oe(o3),
        .pin_three_conv_trigger_en(en), .pin_three_trigger_edge(edge_sel),
        .buck_one_reg_en(r1), .buck_two_reg_en(r2),
        .buck_standby_reg_cmd(sb), .uvlo(uvlo), .irq_n(irq_n),
        .buck_one_on(b1), .buck_two_on(b2), .buck_standby(bs),
        .conv_trigger(trig), .regulator_zero_on(rz),
        .charge_voltage_sel(cv));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] p, input logic [7:0] d);
        i_host.wr(p, d);
        chk(i_host.ok, 1'b1);
    endtask
    task automatic rchk(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] v;
        i_host.rd(p, v);
        chk({i_host.ok, v}, {1'b1, e});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        chk({rz, cv}, 2'b00);
        rchk(ADDR_PINS_ONE_TWO_CFG, RST_PINS_ONE_TWO_CFG);
        rchk(ADDR_PIN_THREE_MISC_CFG, RST_PIN_THREE_MISC_CFG);
        wreg(ADDR_PIN_THREE_MISC_CFG, 8'hff);
        rchk(ADDR_PIN_THREE_MISC_CFG, 8'hff);
        chk({rz, cv}, 2'b11);
        wreg(ADDR_PINS_ONE_TWO_CFG, 8'ha5);
        rchk(ADDR_PINS_ONE_TWO_CFG, 8'ha5);
        wreg(ADDR_PINS_ONE_TWO_CFG, 8'h5a);
        rchk(ADDR_PINS_ONE_TWO_CFG, 8'h5a);
        rchk(8'h1d, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_out();
        wreg(ADDR_PIN_THREE_MISC_CFG, 8'hc6);
        wreg(ADDR_PINS_ONE_TWO_CFG, 8'hf0);
        en = 1'b1;
        d1 = 1'b0;
        d2 = 1'b0;
        d3 = 1'b0;
        tick(3);
        chk({o1, o2, o3, irq_n, n_trig}, 12'h100);
        d1 = 1'b1;
        d2 = 1'b1;
        d3 = 1'b1;
        wreg(ADDR_PINS_ONE_TWO_CFG, 8'hc0);
        wreg(ADDR_PIN_THREE_MISC_CFG, 8'h80);
        chk({o1, o2, o3, p1, p2, p3}, 6'h38);
        wreg(ADDR_PINS_ONE_TWO_CFG, 8'h00);
        wreg(ADDR_PIN_THREE_MISC_CFG, 8'h00);
        chk({o1, o2, o3, irq_n}, 4'h1);
        $display("test outputs done");
    endtask
    task automatic t_trig();
        logic [7:0] n0;
        edge_sel = 1'b1;
        d3 = 1'b0;
        tick(3);
        n0 = n_trig;
        d3 = 1'b1;
        tick(3);
        chk(8'(n_trig - n0), 8'h01);
        d3 = 1'b0;
        tick(3);
        chk(8'(n_trig - n0), 8'h01);
        edge_sel = 1'b0;
        d3 = 1'b1;
        tick(3);
        chk(8'(n_trig - n0), 8'h01);
        d3 = 1'b0;
        tick(3);
        chk(8'(n_trig - n0), 8'h02);
        en = 1'b0;
        d3 = 1'b1;
        tick(3);
        d3 = 1'b0;
        tick(3);
        chk(8'(n_trig - n0), 8'h02);
        $display("test trigger done");
    endtask
    task automatic t_irq();
        d1 = 1'b0;
        wreg(ADDR_PIN_THREE_MISC_CFG, 8'h02);
        d1 = 1'b1;
        tick(3);
        chk(irq_n, 1'b0);
        rchk(ADDR_PIN_THREE_MISC_CFG, 8'h02);
        chk(irq_n, 1'b0);
        d1 = 1'b0;
        tick(3);
        d1 = 1'b1;
        tick(3);
        chk(irq_n, 1'b0);
        rchk(ADDR_PIN_THREE_MISC_CFG, 8'h02);
        chk(irq_n, 1'b1);
        d1 = 1'b0;
        tick(3);
        d1 = 1'b1;
        tick(3);
        chk(irq_n, 1'b0);
        uvlo = 1'b1;
        tick(2);
        uvlo = 1'b0;
        tick(2);
        chk(irq_n, 1'b1);
        wreg(ADDR_PINS_ONE_TWO_CFG, 8'h08);
        wreg(ADDR_PIN_THREE_MISC_CFG, 8'h04);
        d2 = 1'b0;
        tick(3);
        chk(irq_n, 1'b0);
        wreg(ADDR_PINS_ONE_TWO_CFG, 8'h88);
        chk(irq_n, 1'b1);
        d2 = 1'b1;
        $display("test interrupt done");
    endtask
    task automatic t_buck();
        r1 = 1'b1;
        r2 = 1'b1;
        wreg(ADDR_PINS_ONE_TWO_CFG, 8'h05);
        wreg(ADDR_PIN_THREE_MISC_CFG, 8'h01);
        chk({b1, b2}, 2'b10);
        d1 = 1'b0;
        d2 = 1'b0;
        tick(3);
        chk({b1, b2}, 2'b01);
        r2 = 1'b0;
        tick(3);
        chk({b1, b2}, 2'b00);
        sb = 1'b1;
        wreg(ADDR_PINS_ONE_TWO_CFG, 8'h02);
        chk(bs, 1'b1);
        d1 = 1'b1;
        tick(3);
        chk(bs, 1'b0);
        d1 = 1'b0;
        sb = 1'b0;
        tick(3);
        chk(bs, 1'b0);
        $display("test converter done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Guards against a hung serial transfer
    initial begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        {rst, d1, d2, d3} = 4'hf;
        {en, edge_sel, r1, r2, sb, uvlo} = 6'h00;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        tick(2);
        t_regs();
        t_out();
        t_trig();
        t_irq();
        t_buck();
        tally_and_finish();
    end
endmodule

/* sim/pgm_host_model.sv */
`timescale 1ns/1ps
module pgm_host_model
    import pgm_pkg::*;
(
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    logic ok;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // ------------------------------------------------------------
    // Serial master
    // ------------------------------------------------------------
    // Each level holds four clocks; the port needs only one
    task automatic step(input logic c, input logic d);
        scl = c;
        sda_m = d;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic xfer(input logic [7:0] b, input logic e,
                        output logic [7:0] g);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, b[i]);
            step(1'b1, b[i]);
            g[i] = sda;
        end
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        if (e && sda !== 1'b0) begin
            ok = 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] g;
        ok = 1'b1;
        start();
        xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, g);
        xfer(p, 1'b1, g);
        xfer(d, 1'b1, g);
        stop();
    endtask
    // A read is what lets a twice-edged pin drop its interrupt
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] g;
        ok = 1'b1;
        start();
        xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, g);
        xfer(p, 1'b1, g);
        start();
        xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, g);
        xfer(8'hff, 1'b0, d);
        stop();
    endtask
endmodule
